// ### verilog/rwp_top.sv
// rwp_top: rtc wake pin, clock-out gate and four retained scratch words
// assumes aclk is the always-on rtc domain clock and an axi4-lite master
//
// Operation
// - wake output bit clear pulls wake pin low when the direction bit is one; set releases it
// - direction bit zero makes wake pin an input, one an output
// - input wake is active high; output is open drain, active low, pulled up
// - clock-out gate bit drives rtc clock onto its pin when set
// - scratch words keep contents while processor supply is off
// - four 16-bit scratch words read/write any value, reset to zero
// - only aresetn and the soft reset bit reset this block; the bit self-clears
`timescale 1ns/100ps
`default_nettype none
module rwp_top
  import rwp_pkg::*;
#(
  parameter int SRST_CYCLES = rwp_pkg::RWP_SRST_CYCLES
) (
  // clock and power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // wake pin, split for open drain
  input wire logic wake_signal_pin_i,
  output logic wake_signal_pin_o,
  output logic wake_signal_pin_oe_n,
  // rtc clock and gated clock-out
  input wire logic rtc_clk_in,
  output logic clock_out_pin,
  // synchronised wake level for the event logic, held low in output mode
  output logic wake_event
);
  import rwp_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [7:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] pmgt;
    logic [3:0][15:0] scr;
    logic [1:0] srst_cnt;
    logic srst_busy;
    logic pin_oe_n;
    logic clk_out;
    logic wake_evt;
  } rwp_top_s;

  rwp_top_s st_reg;
  rwp_top_s st_next;
  logic wake_in_sync;
  logic clk_sync;

  // ==========================================================
  // pin synchronisers; the rtc clock input is sampled, not used as a clock
  rwp_sync u_wake_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(wake_signal_pin_i),
    .dout(wake_in_sync)
  );
  rwp_sync u_clk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(rtc_clk_in),
    .dout(clk_sync)
  );

  // scratch index from a byte offset, or 4 for none
  function automatic logic [2:0] scr_index(input logic [7:0] a);
    case (a)
      RWP_OFS_SCR_A: scr_index = 3'h0;
      RWP_OFS_SCR_B: scr_index = 3'h1;
      RWP_OFS_SCR_C: scr_index = 3'h2;
      RWP_OFS_SCR_D: scr_index = 3'h3;
      default: scr_index = 3'h4;
    endcase
  endfunction : scr_index

  // merge the low two byte lanes under strobe
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // ==========================================================
  // bus slave, register file and pin logic
  always_comb begin
    logic [2:0] idx;
    logic [15:0] m;
    idx = 3'h0;
    m = 16'h0000;
    st_next = st_reg;
    st_next.awready = 1'b0;
    st_next.wready = 1'b0;
    st_next.arready = 1'b0;
    // soft reset countdown; bus accesses are held off meanwhile
    if (st_reg.srst_busy) begin
      if (st_reg.srst_cnt == 2'(SRST_CYCLES - 1)) begin
        st_next.srst_busy = 1'b0; // self-clearing
        st_next.srst_cnt = 2'h0;
      end else begin
        st_next.srst_cnt = st_reg.srst_cnt + 2'h1;
      end
    end
    // capture address and data independently, either order
    if (s_axi_awvalid && !st_reg.aw_held && !st_reg.awready && !st_reg.srst_busy) begin
      st_next.awready = 1'b1;
      st_next.aw_held = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held && !st_reg.wready && !st_reg.srst_busy) begin
      st_next.wready = 1'b1;
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // write commit once both halves held and response slot free
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RWP_RESP_OKAY;
      idx = scr_index(st_reg.awaddr);
      if (idx != 3'h4) begin
        st_next.scr[idx[1:0]] = merge16(st_reg.scr[idx[1:0]], st_reg.wdata, st_reg.wstrb);
      end else if (st_reg.awaddr == RWP_OFS_PMGT) begin
        m = merge16({11'h000, st_reg.pmgt}, st_reg.wdata, st_reg.wstrb);
        st_next.pmgt = m[4:0] & RWP_PMGT_WMASK; // reserved bits dropped
      end else if (st_reg.awaddr == RWP_OFS_SRST) begin
        if (st_reg.wstrb[1] && st_reg.wdata[RWP_BIT_SRST]) begin
          // soft reset clears this domain only
          st_next.srst_busy = 1'b1;
          st_next.srst_cnt = 2'h0;
          st_next.pmgt = RWP_PMGT_RESET;
          st_next.scr = {4{RWP_SCR_RESET}};
        end
      end else begin
        st_next.bresp = RWP_RESP_SLVERR;
      end
    end
    // read channel
    if (s_axi_rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid && !st_reg.srst_busy) begin
      st_next.arready = 1'b1;
      st_next.rvalid = 1'b1;
      st_next.rresp = RWP_RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      idx = scr_index(s_axi_araddr);
      if (idx != 3'h4) begin
        st_next.rdata[15:0] = st_reg.scr[idx[1:0]];
      end else if (s_axi_araddr == RWP_OFS_PMGT) begin
        st_next.rdata[4:0] = st_reg.pmgt; // bits 15..5 read zero
        st_next.rdata[RWP_BIT_WAKE_IN] = wake_in_sync; // live pin level
      end else if (s_axi_araddr == RWP_OFS_SRST) begin
        st_next.rdata[RWP_BIT_SRST] = st_reg.srst_busy;
      end else begin
        st_next.rresp = RWP_RESP_SLVERR;
      end
    end
    // open drain: enable only when output mode and data bit clear
    st_next.pin_oe_n = !(st_next.pmgt[RWP_BIT_WAKE_DIR] && !st_next.pmgt[RWP_BIT_WAKE_OUT]);
    // input mode sees active-high wake; no event in output mode
    st_next.wake_evt = !st_next.pmgt[RWP_BIT_WAKE_DIR] && wake_in_sync;
    // clock-out gated, low when disabled
    st_next.clk_out = st_next.pmgt[RWP_BIT_CLKOUT] && clk_sync;
    // bandgap and regulator power-down bits stored only, no effect
  end

  // ==========================================================
  // aresetn stands for the rtc power-on reset, never the chip pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.pmgt <= RWP_PMGT_RESET;
      st_reg.pin_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign wake_signal_pin_o = 1'b0; // only ever pulls low
  assign wake_signal_pin_oe_n = st_reg.pin_oe_n;
  assign clock_out_pin = st_reg.clk_out;
  assign wake_event = st_reg.wake_evt;

  // ==========================================================
  // checks
  a_pin_drive_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_reg.pin_oe_n) |-> (st_reg.pmgt[RWP_BIT_WAKE_DIR] && !st_reg.pmgt[RWP_BIT_WAKE_OUT]))
    else $error("wake pin driven while not commanded low");
  a_pin_input_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_reg.pmgt[RWP_BIT_WAKE_DIR] |-> st_reg.pin_oe_n)
    else $error("wake pin driven in input mode");
  a_wake_in_high: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.wake_evt |-> !st_reg.pmgt[RWP_BIT_WAKE_DIR] && $past(wake_in_sync))
    else $error("wake event without high input");
  a_clkout_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(st_next.pmgt[RWP_BIT_CLKOUT]) |-> !clock_out_pin)
    else $error("clock out active while gated off");
  a_scr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_reg.aw_held || !st_reg.w_held || st_reg.bvalid) |=> st_reg.scr == $past(st_reg.scr))
    else $error("scratch changed without a write");
  a_scr_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid && st_reg.awaddr == RWP_OFS_SCR_A && st_reg.wstrb == 4'hF)
    |=> st_reg.scr[0] == $past(st_reg.wdata[15:0]))
    else $error("scratch word not stored");
  a_pmgt_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && $past(s_axi_araddr) == RWP_OFS_PMGT && $rose(s_axi_rvalid)) |-> s_axi_rdata[15:5] == 11'h000)
    else $error("reserved bits read nonzero");
  a_srst_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_reg.srst_busy) |-> st_reg.srst_busy [*3] ##1 !st_reg.srst_busy)
    else $error("soft reset bit not cleared after three cycles");
  a_busy_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.srst_busy |=> !s_axi_arready && !s_axi_awready)
    else $error("access accepted during soft reset");
endmodule : rwp_top
`default_nettype wire

// ### verilog/rwp_pkg.sv
// rwp_pkg: register map, field positions and reset values for the rtc wake pin / scratch block
// assumes a 32-bit axi4-lite register bus, one register per aligned word
package rwp_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] RWP_OFS_PMGT = 8'h00;
  localparam logic [7:0] RWP_OFS_SCR_A = 8'h04;
  localparam logic [7:0] RWP_OFS_SCR_B = 8'h08;
  localparam logic [7:0] RWP_OFS_SCR_C = 8'h0C;
  localparam logic [7:0] RWP_OFS_SCR_D = 8'h10;
  localparam logic [7:0] RWP_OFS_SRST = 8'h14;
  // ==========================================================
  // power/pin control and soft reset field positions
  localparam int RWP_BIT_CLKOUT = 0;
  localparam int RWP_BIT_REG_PD = 1;
  localparam int RWP_BIT_BANDGAP_POWERDOWN = 2;
  localparam int RWP_BIT_WAKE_DIR = 3;
  localparam int RWP_BIT_WAKE_OUT = 4;
  localparam int RWP_BIT_SRST = 15;
  localparam int RWP_BIT_WAKE_IN = 16;
  // writable bits of the power/pin control register
  localparam logic [4:0] RWP_PMGT_WMASK = 5'h1F;
  // ==========================================================
  // reset values
  localparam logic [4:0] RWP_PMGT_RESET = 5'h10;
  localparam logic [15:0] RWP_SCR_RESET = 16'h0000;
  localparam int RWP_SCR_WIDTH = 16;
  // ==========================================================
  // timing: soft reset held for three aclk cycles
  localparam int RWP_SRST_CYCLES = 3;
  // axi response codes
  localparam logic [1:0] RWP_RESP_OKAY = 2'h0;
  localparam logic [1:0] RWP_RESP_SLVERR = 2'h2;
endpackage : rwp_pkg

// ### verilog/rwp_sync.sv
// rwp_sync: three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to aclk
`timescale 1ns/100ps
`default_nettype none
module rwp_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pin and filtered level
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } rwp_sync_s;
  rwp_sync_s st_reg;
  rwp_sync_s st_next;
  // ==========================================================
  // stage one is read only by stage two; level moves when stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.level = st_reg.s3;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign dout = st_reg.level;
endmodule : rwp_sync
`default_nettype wire

// ### verif/rwp_wake_ext.sv
// rwp_wake_ext: board side of the open-drain wake line
// assumes the device pin is split into level and active-low enable
`timescale 1ns/100ps
`default_nettype none
module rwp_wake_ext (
  // device side
  input wire logic pin_o,
  input wire logic pin_oe_n,
  // board side
  input wire logic ext_pull_low,
  output logic pin
);
  // ==========
  // wired line
  // board pull-up wins unless someone sinks the line
  assign pin = (pin_oe_n | pin_o) & ~ext_pull_low;
endmodule : rwp_wake_ext
`default_nettype wire

// ### verif/rwp_top_tb.sv
// rwp_top_tb: self-checking bench for the wake pin / scratch block
// assumes rwp_pkg, rwp_top and rwp_wake_ext are compiled first
`timescale 1ns/100ps
`default_nettype none
module rwp_top_tb;
  import rwp_pkg::*;
  // ==========
  // signals
  logic aclk = 0, aresetn = 0, rtc_clk = 0, ext_low = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pin_o, oe_n, clk_out, wake_event, pin;
  int n_errors = 0, n_checks = 0, div = 0;
  always #10 aclk = ~aclk;
  // slow stand-in rtc clock, far below aclk
  always @(posedge aclk) begin
    div <= (div == 2) ? 0 : div + 1;
    if (div == 2) rtc_clk <= ~rtc_clk;
  end
  // ==========
  // design and board
  rwp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_signal_pin_i(pin),
    .wake_signal_pin_o(pin_o), .wake_signal_pin_oe_n(oe_n), .rtc_clk_in(rtc_clk),
    .clock_out_pin(clk_out), .wake_event(wake_event));
  rwp_wake_ext u_ext (.pin_o(pin_o), .pin_oe_n(oe_n), .ext_pull_low(ext_low), .pin(pin));
  // ==========
  // report and compare
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // bounded wait for a level, then compare it
  task automatic wt(ref logic s, input logic e, input string n);
    for (int i = 0; i < 20 && s !== e; i++) @(posedge aclk);
    chk(n, {31'h0, e}, {31'h0, s});
  endtask : wt
  // ==========
  // bus master: valids held until their own ready edge
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    if (i == 40) chk("bvalid", 32'h1, 32'h0);
    if (i == 40) results();
    bready <= 1'h0;
    chk("bresp", {30'h0, e}, {30'h0, bresp});
    // one edge between calls so bready is never assigned twice in a step
    @(posedge aclk);
  endtask : wrc
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    if (i == 40) chk("rvalid", 32'h1, 32'h0);
    if (i == 40) results();
    rready <= 1'h0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    if (er == RWP_RESP_OKAY) chk("rdata", e, rdata);
    // one edge between calls so rready is never assigned twice in a step
    @(posedge aclk);
  endtask : rdc
  // ==========
  // scenarios
  task automatic t_reset;
    wt(wake_event, 1'h1, "wake_event");
    wt(oe_n, 1'h1, "oe_n");
    rdc(RWP_OFS_PMGT, 32'h0001_0010, RWP_RESP_OKAY);
    for (int k = 0; k < 4; k++) rdc(RWP_OFS_SCR_A + 8'(4 * k), 32'h0, RWP_RESP_OKAY);
  endtask : t_reset
  task automatic t_scratch;
    logic [15:0] v [4] = '{16'hFFFF, 16'hA55A, 16'h0001, 16'h8000};
    for (int k = 0; k < 4; k++) wrc(RWP_OFS_SCR_A + 8'(4 * k), {16'hFFFF, v[k]}, RWP_RESP_OKAY);
    for (int k = 0; k < 4; k++) rdc(RWP_OFS_SCR_A + 8'(4 * k), {16'h0, v[k]}, RWP_RESP_OKAY);
    // low lane only: upper byte of the word must survive
    wstrb <= 4'h1;
    wrc(RWP_OFS_SCR_A, 32'h0000_1234, RWP_RESP_OKAY);
    wstrb <= 4'hF;
    rdc(RWP_OFS_SCR_A, 32'h0000_FF34, RWP_RESP_OKAY);
    wrc(8'h40, 32'h1, RWP_RESP_SLVERR);
    rdc(8'h40, 32'h0, RWP_RESP_SLVERR);
  endtask : t_scratch
  task automatic t_wake;
    wrc(RWP_OFS_PMGT, 32'hFFFF_FFE8, RWP_RESP_OKAY);
    wt(pin, 1'h0, "pin");
    chk("oe_n", 32'h0, {31'h0, oe_n});
    chk("wake_event", 32'h0, {31'h0, wake_event});
    // let the three-flop input synchroniser settle
    repeat (6) @(posedge aclk);
    rdc(RWP_OFS_PMGT, 32'h0000_0008, RWP_RESP_OKAY);
    wrc(RWP_OFS_PMGT, 32'h18, RWP_RESP_OKAY);
    wt(pin, 1'h1, "pin");
    wrc(RWP_OFS_PMGT, 32'h0, RWP_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("oe_n", 32'h1, {31'h0, oe_n});
    wrc(RWP_OFS_PMGT, 32'h10, RWP_RESP_OKAY);
    ext_low <= 1'h1;
    wt(wake_event, 1'h0, "wake_event");
    ext_low <= 1'h0;
    wt(wake_event, 1'h1, "wake_event");
  endtask : t_wake
  task automatic t_clkout;
    logic hi;
    wrc(RWP_OFS_PMGT, 32'h11, RWP_RESP_OKAY);
    wt(clk_out, 1'h1, "clk_out");
    wt(clk_out, 1'h0, "clk_out");
    wt(clk_out, 1'h1, "clk_out");
    wrc(RWP_OFS_PMGT, 32'h10, RWP_RESP_OKAY);
    repeat (3) @(posedge aclk);
    hi = 1'h0;
    repeat (12) begin
      @(posedge aclk);
      hi |= clk_out;
    end
    chk("clk_out", 32'h0, {31'h0, hi});
  endtask : t_clkout
  task automatic t_srst;
    wrc(RWP_OFS_SCR_B, 32'h0000_BEEF, RWP_RESP_OKAY);
    wrc(RWP_OFS_PMGT, 32'h19, RWP_RESP_OKAY);
    wrc(RWP_OFS_SRST, 32'h0000_8000, RWP_RESP_OKAY);
    // software keeps off the bus while the soft reset runs
    repeat (RWP_SRST_CYCLES + 1) @(posedge aclk);
    rdc(RWP_OFS_SRST, 32'h0, RWP_RESP_OKAY);
    rdc(RWP_OFS_SCR_B, 32'h0, RWP_RESP_OKAY);
    wt(wake_event, 1'h1, "wake_event");
    rdc(RWP_OFS_PMGT, 32'h0001_0010, RWP_RESP_OKAY);
  endtask : t_srst
  // ==========
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_scratch();
    t_wake();
    t_clkout();
    t_srst();
    results();
  end
endmodule : rwp_top_tb
`default_nettype wire
